// ==== cfg_loader.sv ====
// Purpose: Configuration loader, integrity check, start-up sequencer
// Assumes: AXI4-Lite register slave; pins arrive unsynchronised
// Notes:   RESETN_I is the program reset pin
// Function
// - Check integrity before and after the last data frame.
// - Check integrity after every block written to the frame register.
// - On mismatch pull init low, abort start-up, stay inactive.
// - Enter start-up only after every check passed.
// - Program reset clears all configuration logic asynchronously.
// - Sequencer has eight phases stepped in order 0 to 7.
// - Start-up releases done, drops tristate, raises write enable.
// - End-of-start-up flag always set in phase 7, internal only.
// - Phase of each event selectable, fixed default order.
// - Optional stall until done high or chosen lock reported.
// - Hold at the done phase until done seen high outside.
// - Waiting on done never delays earlier tristate or write events.
// - Default order releases done first.
// - Drive configuration clock in master modes; source drives in slave.
// - Done pin bidirectional, active or open-drain, sensed for start-up.
// - Init pin open-drain; held low outside delays; low flags error.
// - Data bit 0 serial input, parallel readback output.
// - Data bits 1 to 7 bidirectional in parallel mode only.
// - Serial modes forward data on the daisy-chain output.
// - Mode select pins sampled on the rising init edge.
// - Ignore data until the synchronisation word arrives.
// - Init low during memory clearing, released when done.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "cfgld_cfg.svh"

module cfg_loader (
  input  wire logic            CLK_I,
  input  wire logic            RESETN_I,
  input  wire logic            CE_I,
  input  wire cfgld_pkg::pin_t PINS_I,
  input  wire logic [4:0]      AXI_AWADDR_I,
  input  wire logic            AXI_AWVALID_I,
  output logic                 AXI_AWREADY_O,
  input  wire logic [31:0]     AXI_WDATA_I,
  input  wire logic [3:0]      AXI_WSTRB_I,
  input  wire logic            AXI_WVALID_I,
  output logic                 AXI_WREADY_O,
  output logic [1:0]           AXI_BRESP_O,
  output logic                 AXI_BVALID_O,
  input  wire logic            AXI_BREADY_I,
  input  wire logic [4:0]      AXI_ARADDR_I,
  input  wire logic            AXI_ARVALID_I,
  output logic                 AXI_ARREADY_O,
  output logic [31:0]          AXI_RDATA_O,
  output logic [1:0]           AXI_RRESP_O,
  output logic                 AXI_RVALID_O,
  input  wire logic            AXI_RREADY_I,
  output logic                 CFG_CLK_O,
  output logic                 CFG_CLK_OE_N_O,
  output logic [7:0]           DATA_O,
  output logic [7:0]           DATA_OE_N_O,
  output logic                 DOUT_O,
  output logic                 INIT_O,
  output logic                 INIT_OE_N_O,
  output logic                 DONE_O,
  output logic                 DONE_OE_N_O,
  output logic                 GLOBAL_TRISTATE_O,
  output logic                 GLOBAL_WRITE_ENABLE_O,
  output logic                 END_OF_STARTUP_O
);
  import cfgld_pkg::*;

  pin_t        meta_q, pin_q;
  logic        clk_prev_q;
  state_t      st_q;
  logic [2:0]  mode_q;
  logic [7:0]  clr_q, ccnt_q, wcnt_q;
  logic [5:0]  bcnt_q, bits_d;
  logic [15:0] blk_q, nfrm_q;
  logic [31:0] sh_q, sh_d, crc_q, crc_d;
  logic [2:0]  phase_q;
  logic        ctrl_q;
  logic [17:0] stcfg_q;
  logic        par, mst, own_rise, cfg_rise, dedge, redge, wdone;
  logic        last_blk, chk_pass, chk_fail, stall_ok, hold, adv;
  logic        done_rel_q, gts_q, gwe_q, eos_q;
  logic [1:0]  rb_q;
  logic        aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [4:0]  awaddr_q;
  logic [31:0] wdata_q, wmask, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      meta_q     <= '0;
      pin_q      <= '0;
      clk_prev_q <= 1'b0;
    end else if (CE_I) begin
      meta_q     <= PINS_I;
      pin_q      <= meta_q;
      clk_prev_q <= pin_q.cfg_clk;
    end
  end

  // ------------------------------------------------------------
  // Datapath terms
  // ------------------------------------------------------------
  assign par = (mode_q == `MODE_MPAR) || (mode_q == `MODE_SPAR);
  assign mst = (mode_q == `MODE_MSER) || (mode_q == `MODE_MPAR);
  assign own_rise = (ccnt_q == 8'(`CFG_CLK_HALF_CYC - 1)) && !CFG_CLK_O;
  assign cfg_rise = mst ? own_rise : (pin_q.cfg_clk && !clk_prev_q);
  // Parallel writes need chip select low and direction low
  assign dedge = cfg_rise && (!par || (!pin_q.cs_n && !pin_q.read_write_n));
  assign redge = cfg_rise && par && !pin_q.cs_n && pin_q.read_write_n;
  assign sh_d  = par ? {sh_q[23:0], pin_q.data} : {sh_q[30:0], pin_q.data[0]};
  assign bits_d = bcnt_q + (par ? `STEP_PAR : `STEP_SER);
  assign wdone = dedge && (bits_d == `WORD_BITS)
              && (st_q == ST_LOAD || st_q == ST_CHECK);
  // Running check value, never reset between blocks
  assign crc_d = {crc_q[30:0], 1'b0} ^ (crc_q[31] ? `CRC_POLY : `CRC_INIT) ^ sh_d;
  assign last_blk = (blk_q == nfrm_q - 16'h0001);
  assign chk_pass = (st_q == ST_CHECK) && wdone && (sh_d == crc_q);
  assign chk_fail = (st_q == ST_CHECK) && wdone && (sh_d != crc_q);

  always_comb begin
    unique case (stall_src_t'(stcfg_q[`F_SRC]))
      STL_NONE:   stall_ok = 1'b1;
      STL_DONE:   stall_ok = pin_q.done;
      STL_CMLOCK: stall_ok = pin_q.lock[0];
      STL_ICLOCK: stall_ok = pin_q.lock[1];
    endcase
  end

  // Done-phase hold only blocks stepping, not events already passed
  assign hold = ((phase_q == stcfg_q[`F_DONE]) && !pin_q.done)
             || ((phase_q == stcfg_q[`F_STALL]) && !stall_ok);
  assign adv = (st_q == ST_STARTUP) && cfg_rise && !hold;

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_q <= ST_CLEAR;
    end else if (CE_I) begin
      unique case (st_q)
        ST_CLEAR: begin
          if (clr_q == 8'(`CLEAR_CYC - 1)) begin
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (pin_q.init) begin
            st_q <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (dedge && (sh_d == `SYNC_WORD)) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (wdone && (wcnt_q == `FRAME_WORDS - 8'h01)) begin
            st_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (chk_fail) begin
            st_q <= ST_ERROR;
          end else if (chk_pass) begin
            // Check after next-to-last block precedes the last frame
            st_q <= last_blk ? ST_STARTUP : ST_LOAD;
          end
        end
        ST_STARTUP: begin
          if (adv && (phase_q == `PH_LAST)) begin
            st_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: st_q <= ST_ACTIVE;
        ST_ERROR:  st_q <= ST_ERROR;
        default:   st_q <= ST_ERROR;
      endcase
    end
  end

  // Mode pins caught when init is first seen high
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mode_q <= `MODE_SSER;
    end else if (CE_I && st_q == ST_WAIT && pin_q.init) begin
      mode_q <= pin_q.mode_select;
    end
  end

  // ------------------------------------------------------------
  // Word assembly and block counting
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      clr_q  <= 8'h00;
      sh_q   <= 32'h0000_0000;
      bcnt_q <= 6'h00;
      wcnt_q <= 8'h00;
      blk_q  <= 16'h0000;
      crc_q  <= `CRC_INIT;
    end else if (CE_I) begin
      if (st_q == ST_CLEAR) begin
        clr_q <= clr_q + 8'h01;
      end
      if (dedge) begin
        sh_q <= sh_d;
      end
      if (st_q == ST_SYNC) begin
        bcnt_q <= 6'h00;
        crc_q  <= `CRC_INIT;
      end else if (dedge && (st_q == ST_LOAD || st_q == ST_CHECK)) begin
        bcnt_q <= wdone ? 6'h00 : bits_d;
      end
      if (wdone && st_q == ST_LOAD) begin
        crc_q  <= crc_d;
        wcnt_q <= (wcnt_q == `FRAME_WORDS - 8'h01) ? 8'h00 : wcnt_q + 8'h01;
      end
      if (chk_pass) begin
        blk_q <= blk_q + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Start-up phases and global events
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      phase_q    <= 3'h0;
      eos_q      <= 1'b0;
      done_rel_q <= 1'b0;
      gts_q      <= 1'b1;
      gwe_q      <= 1'b0;
    end else if (CE_I) begin
      if (adv && phase_q != `PH_LAST) begin
        phase_q <= phase_q + 3'h1;
      end
      if (adv && phase_q == `PH_LAST) begin
        eos_q <= 1'b1;
      end
      if (st_q == ST_STARTUP) begin
        // Each event latches once its phase is reached
        if (phase_q >= stcfg_q[`F_DONE]) done_rel_q <= 1'b1;
        if (phase_q >= stcfg_q[`F_GTS])  gts_q <= 1'b0;
        if (phase_q >= stcfg_q[`F_GWE])  gwe_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration pins
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ccnt_q         <= 8'h00;
      CFG_CLK_O      <= 1'b0;
      CFG_CLK_OE_N_O <= 1'b1;
    end else if (CE_I) begin
      // Master clock only after the mode is known
      CFG_CLK_OE_N_O <= !(mst && st_q != ST_CLEAR && st_q != ST_WAIT);
      if (ccnt_q == 8'(`CFG_CLK_HALF_CYC - 1)) begin
        ccnt_q    <= 8'h00;
        CFG_CLK_O <= !CFG_CLK_O;
      end else begin
        ccnt_q <= ccnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      INIT_O      <= 1'b0;
      INIT_OE_N_O <= 1'b0;
      DONE_O      <= 1'b0;
      DONE_OE_N_O <= 1'b0;
      DOUT_O      <= 1'b0;
      DATA_O      <= 8'h00;
      DATA_OE_N_O <= 8'hff;
      rb_q        <= 2'h0;
    end else if (CE_I) begin
      INIT_O      <= 1'b0;
      INIT_OE_N_O <= !(st_q == ST_CLEAR || st_q == ST_ERROR);
      DONE_O      <= done_rel_q;
      DONE_OE_N_O <= ctrl_q ? 1'b0 : done_rel_q;
      if (dedge && !par) begin
        DOUT_O <= pin_q.data[0];
      end else if (par) begin
        DOUT_O <= 1'b0;
      end
      // Readback offers the running check value a byte at a time
      DATA_OE_N_O <= {8{!(par && !pin_q.cs_n && pin_q.read_write_n)}};
      if (redge) begin
        DATA_O <= crc_q[{rb_q, 3'h0} +: 8];
        rb_q   <= rb_q + 2'h1;
      end
    end
  end

  assign GLOBAL_TRISTATE_O     = gts_q;
  assign GLOBAL_WRITE_ENABLE_O = gwe_q;
  assign END_OF_STARTUP_O      = eos_q;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OK;
      awaddr_q <= 5'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      ctrl_q   <= `CTRL_RST;
      stcfg_q  <= `STCFG_RST;
      nfrm_q   <= `NFRM_RST;
    end else if (CE_I) begin
      if (AXI_AWVALID_I && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        wdata_q <= AXI_WDATA_I;
        wstrb_q <= AXI_WSTRB_I;
      end
      if (!aw_rdy_q && !w_rdy_q && !bvalid_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= `RESP_OK;
        unique case (awaddr_q)
          `A_CTRL:  ctrl_q  <= (ctrl_q & ~wmask[0]) | (wdata_q[0] & wmask[0]);
          `A_STCFG: stcfg_q <= (stcfg_q & ~wmask[17:0]) | (wdata_q[17:0] & wmask[17:0]);
          `A_NFRM:  nfrm_q  <= (nfrm_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
          `A_STAT, `A_CRC: bresp_q <= `RESP_OK;
          default:  bresp_q <= `RESP_DEC;
        endcase
      end
      if (bvalid_q && AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OK;
    end else if (CE_I) begin
      if (AXI_ARVALID_I && ar_rdy_q) begin
        ar_rdy_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q  <= `RESP_OK;
        unique case (AXI_ARADDR_I)
          `A_CTRL:  rdata_q <= {31'h0, ctrl_q};
          `A_STCFG: rdata_q <= {14'h0, stcfg_q};
          `A_NFRM:  rdata_q <= {16'h0, nfrm_q};
          `A_STAT:  rdata_q <= {13'h0, done_rel_q, gwe_q, gts_q,
                                1'b0, mode_q, 1'b0, phase_q, st_q};
          `A_CRC:   rdata_q <= crc_q;
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_DEC;
          end
        endcase
      end else if (rvalid_q && AXI_RREADY_I) begin
        rvalid_q <= 1'b0;
        ar_rdy_q <= 1'b1;
      end
    end
  end

  assign AXI_AWREADY_O = aw_rdy_q;
  assign AXI_WREADY_O  = w_rdy_q;
  assign AXI_BVALID_O  = bvalid_q;
  assign AXI_BRESP_O   = bresp_q;
  assign AXI_ARREADY_O = ar_rdy_q;
  assign AXI_RVALID_O  = rvalid_q;
  assign AXI_RDATA_O   = rdata_q;
  assign AXI_RRESP_O   = rresp_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I || !CE_I);

  property p_err_init;
    chk_fail |=> (st_q == ST_ERROR) ##1 (!INIT_OE_N_O && !gwe_q);
  endproperty
  a_err_init: assert property (p_err_init) else $error("init not low after mismatch");

  property p_start_ok;
    $rose(st_q == ST_STARTUP) |-> $past(chk_pass && last_blk);
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("start-up without passing check");

  property p_step;
    (st_q == ST_STARTUP) && $changed(phase_q) |-> phase_q == $past(phase_q) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("phase skipped");

  property p_eos;
    $rose(eos_q) |-> $past(phase_q) == `PH_LAST && st_q == ST_ACTIVE;
  endproperty
  a_eos: assert property (p_eos) else $error("end flag outside last phase");

  property p_done_hold;
    (st_q == ST_STARTUP) && (phase_q == stcfg_q[`F_DONE]) && !pin_q.done
      |=> $stable(phase_q);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("left done phase early");

  property p_gts;
    (st_q == ST_STARTUP) && (phase_q >= stcfg_q[`F_GTS]) |=> !gts_q;
  endproperty
  a_gts: assert property (p_gts) else $error("tristate release delayed");

  property p_sync;
    (st_q == ST_SYNC) |=> (crc_q == `CRC_INIT) && (blk_q == 16'h0000);
  endproperty
  a_sync: assert property (p_sync) else $error("data taken before sync");

  property p_clear;
    (st_q == ST_CLEAR) ##1 (st_q == ST_CLEAR) |-> !INIT_OE_N_O && !INIT_O;
  endproperty
  a_clear: assert property (p_clear) else $error("init released while clearing");

  property p_blk_chk;
    wdone && (st_q == ST_LOAD) && (wcnt_q == `FRAME_WORDS - 8'h01) |=> st_q == ST_CHECK;
  endproperty
  a_blk_chk: assert property (p_blk_chk) else $error("block not checked");

  property p_mode;
    (st_q == ST_WAIT) && pin_q.init |=> mode_q == $past(pin_q.mode_select);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not sampled");

endmodule // cfg_loader

// ==== cfg_source.sv ====
// Purpose: Slave-serial configuration source model
// Assumes: 320 ns bit time, data changes on the falling clock
// Notes:   Clock stands still between calls
`timescale 1ns/1ps
module cfg_source (
  output logic       cfg_clk_o,
  output logic [7:0] data_o
);
  initial begin
    cfg_clk_o = 1'b0;
    data_o    = 8'h55;
  end
  // Unused upper lines toggle, never a steady copy
  task automatic bit_out(input logic b);
    data_o = {{7{~data_o[7]}}, b};
    #160 cfg_clk_o = 1'b1;
    #160 cfg_clk_o = 1'b0;
  endtask
  // Offset keeps link edges off the system clock edges
  task automatic send_word(input logic [31:0] w);
    #13;
    for (int i = 31; i >= 0; i--) bit_out(w[i]);
    data_o = ~data_o;
  endtask
  task automatic idle(input int n);
    #13;
    repeat (n) bit_out(~data_o[0]);
  endtask
endmodule // cfg_source

// ==== cfgld_cfg.svh ====
// Purpose: Constants of the configuration loader
// Assumes: 25 MHz system clock
// Notes:   Definitions only
`ifndef CFGLD_CFG_SVH
`define CFGLD_CFG_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ        25
`define CLEAR_NS       4000
`define CLEAR_CYC      (((`CLEAR_NS * `CLK_MHZ) + 999) / 1000)
`define CFG_CLK_HALF_NS   160
`define CFG_CLK_HALF_CYC  ((`CFG_CLK_HALF_NS * `CLK_MHZ) / 1000)

// ------------------------------------------------------------
// Stream format
// ------------------------------------------------------------
`define SYNC_WORD      32'h5a3c_c3a5
`define CRC_POLY       32'h04c1_1db7
`define CRC_INIT       32'h0000_0000
`define FRAME_WORDS    8'h08
`define WORD_BITS      6'h20
`define STEP_SER       6'h01
`define STEP_PAR       6'h08
`define PH_LAST        3'h7

// ------------------------------------------------------------
// Mode select codes
// ------------------------------------------------------------
`define MODE_MSER      3'h0
`define MODE_SSER      3'h7
`define MODE_MPAR      3'h3
`define MODE_SPAR      3'h6

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define A_CTRL         5'h00
`define A_STCFG        5'h04
`define A_NFRM         5'h08
`define A_STAT         5'h0c
`define A_CRC          5'h10
`define CTRL_RST       1'h0
`define STCFG_RST      18'h0_0321
`define NFRM_RST       16'h0004
`define F_DONE         2:0
`define F_GTS          6:4
`define F_GWE          10:8
`define F_STALL        14:12
`define F_SRC          17:16
`define RESP_OK        2'h0
`define RESP_DEC       2'h3

`endif

// ==== cfgld_pkg.sv ====
// Purpose: Types of the configuration loader
// Assumes: Constants live in cfgld_cfg.svh
// Notes:   One-hot state codes
package cfgld_pkg;

  typedef enum logic [7:0] {
    ST_CLEAR   = 8'h01,
    ST_WAIT    = 8'h02,
    ST_SYNC    = 8'h04,
    ST_LOAD    = 8'h08,
    ST_CHECK   = 8'h10,
    ST_STARTUP = 8'h20,
    ST_ACTIVE  = 8'h40,
    ST_ERROR   = 8'h80
  } state_t;

  typedef enum logic [1:0] {
    STL_NONE   = 2'h0,
    STL_DONE   = 2'h1,
    STL_CMLOCK = 2'h2,
    STL_ICLOCK = 2'h3
  } stall_src_t;

  // Configuration pins seen from outside
  typedef struct packed {
    logic       cfg_clk;
    logic [7:0] data;
    logic       cs_n;
    logic       read_write_n;
    logic       init;
    logic       done;
    logic [2:0] mode_select;
    logic [1:0] lock;
  } pin_t;

endpackage

// ==== config_load_crc_startup_sequencer_bench.sv ====
// Purpose: Self-checking bench of the configuration loader
// Assumes: Slave serial mode, open-drain done and init with pull-ups
// Notes:   Registers reached over AXI4-Lite
`timescale 1ns/1ps
`include "cfgld_cfg.svh"
module config_load_crc_startup_sequencer_bench;
  import cfgld_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, ext_done_low = 1'b0;
  logic        ce = 1'b1;
  logic [1:0]  lock = 2'h0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cfg_clk_oe_n, dout;
  logic        init_o, init_oe_n, done_o, done_oe_n, global_tristate, global_write_enable, end_of_startup, scl, init_w, done_w;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  sdat, data_oe_n;
  pin_t        pins;
  int          num_errors = 0, tests_run = 0, cycles = 0;

  always #20 clk = ~clk;
  assign init_w = init_oe_n ? 1'b1 : init_o;
  assign done_w = (done_oe_n ? 1'b1 : done_o) & ~ext_done_low;
  assign pins = {scl, sdat, 1'b1, 1'b0, init_w, done_w, 3'h7, lock};

  cfg_source src (.cfg_clk_o(scl), .data_o(sdat));
  cfg_loader dut (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .PINS_I(pins),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
    .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
    .CFG_CLK_O(), .CFG_CLK_OE_N_O(cfg_clk_oe_n), .DATA_O(), .DATA_OE_N_O(data_oe_n),
    .DOUT_O(dout),
    .INIT_O(init_o), .INIT_OE_N_O(init_oe_n), .DONE_O(done_o), .DONE_OE_N_O(done_oe_n),
    .GLOBAL_TRISTATE_O(global_tristate), .GLOBAL_WRITE_ENABLE_O(global_write_enable), .END_OF_STARTUP_O(end_of_startup));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(r));
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, m, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", e, d & m);
  endtask
  task automatic load(input int nblk, input logic bad);
    logic [31:0] crc, w;
    crc = `CRC_INIT;
    src.send_word(`SYNC_WORD);
    rd(`A_CRC, 32'h0, 32'hffff_ffff, 2'h0);
    chk("dout", 32'h1, 32'(dout));
    for (int b = 0; b < nblk; b++) begin
      for (int i = 0; i < 8; i++) begin
        w = 32'h1234_0000 | 32'(b * 8 + i);
        src.send_word(w);
        crc = {crc[30:0], 1'b0} ^ (crc[31] ? `CRC_POLY : 32'h0) ^ w;
      end
      src.send_word(bad ? ~crc : crc);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(`A_CTRL, 32'h0, 32'hffff_ffff, 2'h0);
    rd(`A_STCFG, 32'h0000_0321, 32'hffff_ffff, 2'h0);
    rd(`A_NFRM, 32'h4, 32'hffff_ffff, 2'h0);
    rd(5'h14, 32'h0, 32'hffff_ffff, 2'h3);
    wr(5'h18, 32'h1, 2'h3);
    #1 chk("init_oe_n", 32'h0, 32'(init_oe_n));
    // Enable low for 20 cycles stretches clearing by as much
    @(posedge clk) ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    repeat (80) @(posedge clk);
    #1 chk("init_oe_n", 32'h0, 32'(init_oe_n));
    repeat (20) @(posedge clk);
    #1 chk("init_oe_n", 32'h1, 32'(init_oe_n));
    chk("cfg_clk_oe_n", 32'h1, 32'(cfg_clk_oe_n));
    rd(`A_STAT, 32'h7000, 32'h7000, 2'h0);
    $display("test reset_and_map done");
    wr(`A_NFRM, 32'h2, 2'h0);
    wr(`A_STCFG, 32'h0002_1213, 2'h0);
    @(posedge clk) ext_done_low <= 1'b1;
    src.send_word(32'hffff_0000);
    load(2, 1'b0);
    src.idle(24);
    // Stalled at phase 1 on lock 0; tristate already released
    rd(`A_STAT, 32'h0000_7120, 32'hffff_ffff, 2'h0);
    chk("gts_gwe_eos", 32'h0, 32'({global_tristate, global_write_enable, end_of_startup}));
    @(posedge clk) lock <= 2'h1;
    src.idle(24);
    rd(`A_STAT, 32'h0006_7320, 32'hffff_ffff, 2'h0);
    chk("gts_gwe_eos", 32'h2, 32'({global_tristate, global_write_enable, end_of_startup}));
    chk("done_oe_n", 32'h1, 32'(done_oe_n));
    @(posedge clk) ext_done_low <= 1'b0;
    src.idle(16);
    rd(`A_STAT, 32'h0006_7740, 32'hffff_ffff, 2'h0);
    chk("gts_gwe_eos", 32'h3, 32'({global_tristate, global_write_enable, end_of_startup}));
    wr(`A_CTRL, 32'h1, 2'h0);
    #1 chk("done_pin", 32'h1, 32'({done_oe_n, done_o}));
    chk("data_oe_n", 32'hff, 32'(data_oe_n));
    $display("test good_load done");
    @(posedge clk) rst_n <= 1'b0;
    #1 chk("gts_gwe_eos", 32'h4, 32'({global_tristate, global_write_enable, end_of_startup}));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (110) @(posedge clk);
    wr(`A_NFRM, 32'h2, 2'h0);
    load(1, 1'b1);
    src.idle(24);
    #1 chk("init_oe_n", 32'h0, 32'(init_oe_n));
    rd(`A_STAT, 32'h0001_0080, 32'h0003_00ff, 2'h0);
    chk("gts_gwe_eos", 32'h4, 32'({global_tristate, global_write_enable, end_of_startup}));
    $display("test bad_check done");
    final_report();
  end
endmodule // config_load_crc_startup_sequencer_bench
